// File: src/status_reporter_consts.vh
// Purpose: constants for the delivery status reporter
// Assumes: word-aligned avalon byte addresses
// Notes:   definitions only
`ifndef STATUS_REPORTER_CONSTS_VH
`define STATUS_REPORTER_CONSTS_VH
// register byte addresses
`define ADDR_CTRL      11'h000
`define ADDR_PHASE     11'h004
`define ADDR_CMD       11'h008
`define ADDR_STAT      11'h00c
`define ADDR_FLD_BASE  11'h400
// ctrl bit positions
`define CTRL_COMBINED  0
`define CTRL_PRESET    1
`define CTRL_COMP_EN   2
`define CTRL_PROD_LO   3
`define CTRL_DATE_US   5
`define CTRL_SETUP     6
`define CTRL_BELOW_MIN 7
`define CTRL_RESET     8'h00
// product types in ctrl[4:3]
`define PROD_LPG       2'h1
`define PROD_PETRO     2'h2
// stat bits
`define STAT_BUSY      0
`define STAT_REJECT    1
// commands written to cmd register
`define CMD_STATUS     4'h0
`define CMD_TOTALS     4'h1
`define CMD_AUX        4'h2
`define CMD_CLOCK      4'h3
`define CMD_RATE       4'h4
`define CMD_PRESET_Q   4'h5
`define CMD_DENSITY_Q  4'h6
`define CMD_SET_PRESET 4'h7
`define CMD_SET_DENS   4'h8
`define CMD_TC         4'h9
`define CMD_START      4'ha
`define CMD_STOP       4'hb
`define CMD_PRINT      4'hc
// reply kinds
`define RK_STATUS      3'h0
`define RK_TOTALS      3'h1
`define RK_AUX         3'h2
`define RK_CLOCK       3'h3
`define RK_RATE        3'h4
`define RK_PRESET      3'h5
`define RK_DENSITY     3'h6
`define RK_BUSY        3'h7
// reply items: 0..31 are text fields
`define F_ID      6'h00
`define F_DELNO   6'h01
`define F_NET     6'h02
`define F_GROSS   6'h03
`define F_FINISH  6'h04
`define F_START   6'h05
`define F_AVTEMP  6'h06
`define F_PRESET  6'h07
`define F_TRUCK   6'h08
`define F_ENDDATE 6'h09
`define F_STIME   6'h0a
`define F_FTIME   6'h0b
`define F_METER   6'h0c
`define F_UNITS   6'h0d
`define F_DATE    6'h0e
`define F_TIME    6'h0f
`define F_RATE    6'h10
`define F_TEMP    6'h11
`define F_DENSITY 6'h12
`define IT_STATUS 6'h20
`define IT_DFMT   6'h21
`define IT_BUSY   6'h22
`define IT_CKSUM  6'h23
`define IT_END    6'h3f
// status codes with special handling
`define SC_SETUP  8'h0c
`define SC_NOTOT  8'h0e
// ascii
`define CH_SPACE  8'h20
`define CH_CR     8'h0d
`define CH_LF     8'h0a
`define CH_ZERO   8'h30
`define CH_S      8'h53
`define CH_BUSY0  8'h44
`define CH_BUSY1  8'h53
`endif

// File: src/delivery_status_reporter.v
// Purpose: builds ascii replies to hand-held queries and streams them out
// Assumes: host cpu fills text fields and phase over avalon-mm; a uart takes tx bytes
// Notes:   one reply at a time; cmd writes stall with waitrequest while busy
`timescale 1ns/10ps
`default_nettype none
`include "status_reporter_consts.vh"

module delivery_status_reporter #(
    parameter FLD_LEN = 8                     // bytes per text field
) (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire [10:0] avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    output reg  [7:0]  tx_data_o,
    output reg         tx_valid_o,
    input  wire        tx_ready_i
);

    // one-hot engine states
    localparam [5:0] S_IDLE  = 6'b000001;
    localparam [5:0] S_PICK  = 6'b000010;
    localparam [5:0] S_SPACE = 6'b000100;
    localparam [5:0] S_EMIT  = 6'b001000;
    localparam [5:0] S_CR    = 6'b010000;
    localparam [5:0] S_LF    = 6'b100000;

    reg [7:0]  fld_mem [0:32*FLD_LEN-1];      // text fields, zero ends a field
    reg [7:0]  ctrl_r;                        // mode and condition bits
    reg [3:0]  phase_r;                       // delivery phase from host
    reg        reject_r;                      // sticky: command refused
    reg [3:0]  last_cmd_r;                    // last command accepted
    reg        rd_done_r;                     // read wait-state tracker
    reg [5:0]  state_r;                       // engine state
    reg [2:0]  kind_r;                        // reply being sent
    reg [3:0]  step_r;                        // item index in reply
    reg [3:0]  idx_r;                         // char index in item
    reg        first_r;                       // no item sent yet
    reg [7:0]  cks_r;                         // running byte sum
    reg [7:0]  code_r;                        // status code latched at command

    wire       idle     = state_r[0];
    wire       can_send = ~tx_valid_o | tx_ready_i;
    wire       cmd_wr   = avs_write_i & (avs_address_i == `ADDR_CMD);
    wire       fld_sel  = (avs_address_i >= `ADDR_FLD_BASE);
    wire [7:0] fld_addr = avs_address_i[9:2];

    // reads take one wait cycle; cmd writes wait until the engine is idle
    assign avs_waitrequest_o = (avs_read_i & ~rd_done_r) | (cmd_wr & ~idle);

    // phase to status code; mode decides the ticket codes
    function [7:0] status_code;
        input [3:0] ph;
        input       combined;
        input       setup;
        begin
            if (setup)
                status_code = `SC_SETUP;
            else if (~combined && (ph == 4'h9 || ph == 4'hb))
                status_code = {4'h0, ph} - 8'h01;
            else
                status_code = {4'h0, ph};
        end
    endfunction

    // item list for each reply kind
    function [5:0] seq_item;
        input [2:0] kind;
        input [3:0] step;
        begin
            seq_item = `IT_END;
            if (step == 4'h0)
                seq_item = `F_ID;
            else case (kind)
                `RK_STATUS: if (step == 4'h1) seq_item = `IT_STATUS;
                `RK_BUSY:   if (step == 4'h1) seq_item = `IT_BUSY;
                `RK_TOTALS: case (step)
                    4'h1: seq_item = `F_DELNO;
                    4'h2: seq_item = `F_NET;
                    4'h3: seq_item = `F_GROSS;
                    4'h4: seq_item = `F_FINISH;
                    4'h5: seq_item = `F_START;
                    4'h6: seq_item = `F_AVTEMP;
                    4'h7: seq_item = `F_PRESET;
                    4'h8: seq_item = `F_TRUCK;
                    4'h9: seq_item = `IT_CKSUM;
                    default: seq_item = `IT_END;
                endcase
                `RK_AUX: case (step)
                    4'h1: seq_item = `F_ENDDATE;
                    4'h2: seq_item = `F_STIME;
                    4'h3: seq_item = `F_FTIME;
                    4'h4: seq_item = `F_METER;
                    4'h5: seq_item = `F_UNITS;
                    4'h6: seq_item = `IT_CKSUM;
                    default: seq_item = `IT_END;
                endcase
                `RK_CLOCK: case (step)
                    4'h1: seq_item = `F_DATE;
                    4'h2: seq_item = `F_TIME;
                    4'h3: seq_item = `IT_DFMT;
                    4'h4: seq_item = `IT_CKSUM;
                    default: seq_item = `IT_END;
                endcase
                `RK_RATE: case (step)
                    4'h1: seq_item = `F_RATE;
                    4'h2: seq_item = `F_TEMP;
                    default: seq_item = `IT_END;
                endcase
                `RK_PRESET:  if (step == 4'h1) seq_item = `F_PRESET;
                default:     if (step == 4'h1) seq_item = `F_DENSITY;
            endcase
        end
    endfunction

    // optional fields depend on configuration
    function item_on;
        input [5:0] it;
        input [2:0] kind;
        input [7:0] ctrl;
        begin
            if (kind == `RK_TOTALS && (it == `F_GROSS || it == `F_AVTEMP))
                item_on = ctrl[`CTRL_COMP_EN];
            else if (kind == `RK_TOTALS && it == `F_PRESET)
                item_on = ctrl[`CTRL_PRESET];
            else if (it == `F_TEMP)
                item_on = ctrl[`CTRL_COMP_EN];
            else
                item_on = 1'b1;
        end
    endfunction

    // density commands need a product type with a density table
    function dens_ok;
        input [1:0] prod;
        begin
            dens_ok = (prod == `PROD_LPG) || (prod == `PROD_PETRO);
        end
    endfunction

    wire [5:0] item   = seq_item(kind_r, step_r);
    wire [7:0] fchar  = fld_mem[{item[4:0], idx_r[2:0]}];
    wire       f_last = (idx_r == FLD_LEN[3:0]);

    // current character of the item and whether one remains
    reg [7:0] ch;
    reg       ch_ok;
    always @*
    begin
        ch    = 8'h00;
        ch_ok = 1'b0;
        if (~item[5])
        begin
            ch    = fchar;
            ch_ok = ~f_last && (fchar != 8'h00);
        end
        else if (item == `IT_STATUS)
        begin
            ch_ok = (idx_r < 4'h3);
            if (idx_r == 4'h0)
                ch = `CH_S;
            else if (idx_r == 4'h1)
                ch = (code_r >= 8'h0a) ? 8'h31 : `CH_ZERO;
            else
                ch = `CH_ZERO + ((code_r >= 8'h0a) ? code_r - 8'h0a : code_r);
        end
        else if (item == `IT_DFMT)
        begin
            ch_ok = (idx_r == 4'h0);
            ch    = `CH_ZERO + {7'h00, ctrl_r[`CTRL_DATE_US]};
        end
        else if (item == `IT_BUSY)
        begin
            ch_ok = (idx_r < 4'h2);
            ch    = (idx_r == 4'h0) ? `CH_BUSY0 : `CH_BUSY1;
        end
        else if (item == `IT_CKSUM)
        begin
            ch_ok = (idx_r == 4'h0);
            ch    = cks_r;
        end
    end

    // first char of a field tells whether the field is empty
    wire item_empty = ~item[5] && (fld_mem[{item[4:0], 3'h0}] == 8'h00);

    // field memory writes; no reset so it maps to ram
    always @(posedge clk_i)
    begin
        if (avs_write_i && fld_sel)
            fld_mem[fld_addr] <= avs_writedata_i[7:0];
    end

    wire [3:0] cmd_code = avs_writedata_i[3:0];   // command field of a cmd write
    reg  [2:0] cmd_kind;                          // reply kind for that command
    reg        cmd_refused;                       // command not allowed now

    // host registers and command decode
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_r     <= `CTRL_RESET;
            phase_r    <= 4'h0;
            reject_r   <= 1'b0;
            last_cmd_r <= 4'h0;
            rd_done_r  <= 1'b0;
        end
        else
        begin
            rd_done_r <= avs_read_i & ~rd_done_r;
            if (avs_write_i && avs_address_i == `ADDR_CTRL)
                ctrl_r <= avs_writedata_i[7:0];
            else if (avs_write_i && avs_address_i == `ADDR_PHASE)
                phase_r <= avs_writedata_i[3:0];
            // refusal on a taken command beats a software clear
            if (cmd_wr && idle && cmd_refused)
                reject_r <= 1'b1;
            else if (avs_write_i && avs_address_i == `ADDR_STAT
                     && avs_writedata_i[`STAT_REJECT])
                reject_r <= 1'b0;
            if (cmd_wr && idle && ~cmd_refused)
                last_cmd_r <= avs_writedata_i[3:0];
        end
    end

    // command to reply kind
    always @*
    begin
        cmd_kind    = `RK_STATUS;
        cmd_refused = 1'b0;
        if (ctrl_r[`CTRL_SETUP])
            cmd_kind = `RK_BUSY;
        else case (cmd_code)
            `CMD_TOTALS: cmd_kind = ctrl_r[`CTRL_BELOW_MIN] ? `RK_STATUS : `RK_TOTALS;
            `CMD_AUX:    cmd_kind = `RK_AUX;
            `CMD_CLOCK:  cmd_kind = `RK_CLOCK;
            `CMD_RATE:   cmd_kind = `RK_RATE;
            `CMD_PRESET_Q, `CMD_SET_PRESET:
            begin
                cmd_kind    = `RK_PRESET;
                cmd_refused = ~ctrl_r[`CTRL_PRESET];
            end
            `CMD_DENSITY_Q, `CMD_SET_DENS:
            begin
                cmd_kind    = `RK_DENSITY;
                cmd_refused = ~dens_ok(ctrl_r[4:3]);
            end
            `CMD_STATUS, `CMD_TC, `CMD_START, `CMD_STOP, `CMD_PRINT:
                cmd_kind = `RK_STATUS;
            default:     cmd_refused = 1'b1;
        endcase
    end

    // code 14 when a totals or print request meets an empty report, or when phase 14 is set
    wire no_totals = ctrl_r[`CTRL_BELOW_MIN] && ~ctrl_r[`CTRL_SETUP]
                     && (cmd_code == `CMD_TOTALS || cmd_code == `CMD_PRINT);

    // reply engine
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_r    <= S_IDLE;
            kind_r     <= `RK_STATUS;
            step_r     <= 4'h0;
            idx_r      <= 4'h0;
            first_r    <= 1'b1;
            cks_r      <= 8'h00;
            code_r     <= 8'h00;
            tx_data_o  <= 8'h00;
            tx_valid_o <= 1'b0;
        end
        else
        begin
            // byte leaves once the uart takes it
            if (tx_valid_o && tx_ready_i)
                tx_valid_o <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    if (cmd_wr && ~cmd_refused)
                    begin
                        kind_r  <= cmd_kind;
                        step_r  <= 4'h0;
                        idx_r   <= 4'h0;
                        first_r <= 1'b1;
                        cks_r   <= 8'h00;
                        code_r  <= no_totals ? `SC_NOTOT
                                 : status_code(phase_r, ctrl_r[`CTRL_COMBINED],
                                               ctrl_r[`CTRL_SETUP]);
                        state_r <= S_PICK;
                    end
                end
                S_PICK:
                begin
                    idx_r <= 4'h0;
                    if (item == `IT_END)
                        state_r <= S_CR;
                    else if (~item_on(item, kind_r, ctrl_r) || item_empty)
                        step_r <= step_r + 4'h1;
                    else if (first_r)
                        state_r <= S_EMIT;
                    else
                        state_r <= S_SPACE;
                end
                S_SPACE:
                begin
                    if (can_send)
                    begin
                        tx_data_o  <= `CH_SPACE;
                        tx_valid_o <= 1'b1;
                        cks_r      <= cks_r + `CH_SPACE;
                        state_r    <= S_EMIT;
                    end
                end
                S_EMIT:
                begin
                    if (~ch_ok)
                    begin
                        first_r <= 1'b0;
                        step_r  <= step_r + 4'h1;
                        state_r <= S_PICK;
                    end
                    else if (can_send)
                    begin
                        tx_data_o  <= ch;
                        tx_valid_o <= 1'b1;
                        cks_r      <= cks_r + ch;
                        idx_r      <= idx_r + 4'h1;
                    end
                end
                S_CR:
                begin
                    if (can_send)
                    begin
                        tx_data_o  <= `CH_CR;
                        tx_valid_o <= 1'b1;
                        state_r    <= S_LF;
                    end
                end
                S_LF:
                begin
                    // engine frees only after lf, so replies never interleave
                    if (can_send)
                    begin
                        tx_data_o  <= `CH_LF;
                        tx_valid_o <= 1'b1;
                        state_r    <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // read data registered in the wait cycle; unmapped words read zero
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (avs_address_i == `ADDR_CTRL)
            avs_readdata_o <= {24'h000000, ctrl_r};
        else if (avs_address_i == `ADDR_PHASE)
            avs_readdata_o <= {28'h0000000, phase_r};
        else if (avs_address_i == `ADDR_CMD)
            avs_readdata_o <= {28'h0000000, last_cmd_r};
        else if (avs_address_i == `ADDR_STAT)
            avs_readdata_o <= {16'h0000, code_r, 6'h00, reject_r, ~idle};
        else if (fld_sel)
            avs_readdata_o <= {24'h000000, fld_mem[fld_addr]};
        else
            avs_readdata_o <= 32'h0000_0000;
    end

endmodule // delivery_status_reporter
`default_nettype wire

// File: testbench/status_reporter_asserts.sv
// Purpose: property checks on the reporter's bus and byte stream
// Assumes: one clock domain, reset active low
// Notes:   shadows ctrl writes to know the configured modes
`timescale 1ns/10ps
`default_nettype none
`include "status_reporter_consts.vh"
module status_reporter_asserts #(
    parameter FLD_LEN = 8                          // unused, kept in step with the design
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [10:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [31:0] avs_readdata_o,
    input  wire logic        avs_waitrequest_o,
    input  wire logic [7:0]  tx_data_o,
    input  wire logic        tx_valid_o,
    input  wire logic        tx_ready_i
);
    logic [7:0] prev_r;                            // last byte the uart took
    logic [7:0] ctrl_r;                            // shadow of the ctrl register
    wire        acc  = tx_valid_o && tx_ready_i;   // byte handed over
    wire        cmdw = avs_write_i && !avs_waitrequest_o && avs_address_i == `ADDR_CMD;
    // helper state, so checks can look one byte back
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            prev_r <= 8'h00;
            ctrl_r <= `CTRL_RESET;
        end
        else
        begin
            if (acc)
                prev_r <= tx_data_o;
            if (avs_write_i && !avs_waitrequest_o && avs_address_i == `ADDR_CTRL)
                ctrl_r <= avs_writedata_i[7:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("tx byte changed before acceptance");
    chk_tx_drop: assert property ($fell(tx_valid_o) |-> $past(tx_ready_i))
        else $error("tx valid fell without acceptance");
    chk_ctrl_readback: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == `ADDR_CTRL |-> avs_readdata_o[7:0] == ctrl_r)
        else $error("ctrl read differs from last write");
    chk_reply_start: assert property (cmdw && avs_writedata_i[3:0] == `CMD_STATUS |-> ##[1:8] tx_valid_o)
        else $error("status query got no reply");
    chk_reply_end: assert property (acc && tx_data_o == `CH_LF && prev_r == `CH_CR |=> !tx_valid_o)
        else $error("bytes sent after line end");
    chk_preset_refused: assert property (cmdw && avs_writedata_i[3:0] == `CMD_PRESET_Q && !ctrl_r[1] && !ctrl_r[6] |=> !tx_valid_o [*8])
        else $error("preset query answered outside preset mode");
    chk_dens_refused: assert property (cmdw && avs_writedata_i[3:0] == `CMD_DENSITY_Q && ctrl_r[4:3] != `PROD_LPG && ctrl_r[4:3] != `PROD_PETRO && !ctrl_r[6] |=> !tx_valid_o [*8])
        else $error("density query answered without product");
    chk_busy_token: assert property (acc && ctrl_r[6] && prev_r == `CH_SPACE |-> tx_data_o == `CH_BUSY0)
        else $error("setup mode reply lacks busy token");
    cover property (acc && tx_data_o == `CH_LF);
    cover property (tx_valid_o && !tx_ready_i);
    cover property (acc && ctrl_r[6]);
endmodule // status_reporter_asserts
`default_nettype wire

// File: testbench/uart_sink.sv
// Purpose: uart stand-in that takes reply bytes
// Assumes: same clock as the reporter
// Notes:   slow mode accepts at most one byte in three cycles
`timescale 1ns/10ps
`default_nettype none
module uart_sink (
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic [7:0] data_i,
    input  wire logic       valid_i,
    input  wire logic       slow_i,
    output var  logic       ready_o,
    output var  logic       got_o,
    output var  logic [7:0] byte_o
);
    logic [1:0] div_r;                             // pacing counter
    // ready pacing and capture of each accepted byte
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            div_r   <= 2'h0;
            ready_o <= 1'b0;
            got_o   <= 1'b0;
            byte_o  <= 8'h00;
        end
        else
        begin
            div_r   <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
            ready_o <= !slow_i || (div_r == 2'h1); // stalls exercise the hold path
            got_o   <= valid_i && ready_o;         // one pulse per byte taken
            byte_o  <= data_i;
        end
    end
endmodule // uart_sink
`default_nettype wire

// File: testbench/tb_delivery_status_reporter.sv
// Purpose: drives queries and checks every reply byte
// Assumes: fields and modes set over the register bus
// Notes:   one query at a time, next only after the line end
`timescale 1ns/10ps
`default_nettype none
`include "status_reporter_consts.vh"
module tb_delivery_status_reporter;
    logic        clk_i;              // 20 MHz
    logic        reset_n_i;          // active low
    logic [10:0] avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [7:0]  tx_data_o;
    logic        tx_valid_o;
    logic        ready;              // uart ready
    logic        slow;               // uart pacing choice
    logic        got;                // byte taken pulse
    logic [7:0]  rx_byte;            // byte taken
    logic [31:0] q;                  // last read word
    logic [7:0]  rx_q[$];            // reply as received
    logic [7:0]  exp_q[$];           // reply as expected
    int          error_cnt;
    int          num_checks;
    string       fv[19] = '{"7", "12", "50.5", "51.0", "900", "849", "15", "60", "T9",
        "01/02/03", "10:00", "10:30", "3", "L", "04/05/06", "11:22:33", "20.1", "14.2", "0.51"};
    delivery_status_reporter #(.FLD_LEN(8)) DUT (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(ready));
    uart_sink sink (.clk_i(clk_i), .reset_n_i(reset_n_i), .data_i(tx_data_o),
        .valid_i(tx_valid_o), .slow_i(slow), .ready_o(ready), .got_o(got), .byte_o(rx_byte));
    // free running clock
    always #25 clk_i = ~clk_i;
    // collect on the falling edge, away from the sink's updates
    always @(negedge clk_i)
        if (got === 1'b1)
            rx_q.push_back(rx_byte);
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        @(posedge clk_i);
        // no local limit: only the watchdog ends a stalled transfer
        while (avs_waitrequest_o !== 1'b0)
            @(posedge clk_i);
        q = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask
    // send a query, wait for the line end, compare byte by byte
    task automatic run(input logic [3:0] c, input string s, input bit k);
        logic [7:0] sum;
        int         n;
        sum = 8'h00;
        n = 0;
        exp_q.delete();
        foreach (s[i]) exp_q.push_back(s[i]);
        if (k)
        begin
            exp_q.push_back(`CH_SPACE);
            foreach (exp_q[i]) sum += exp_q[i];
            exp_q.push_back(sum);
        end
        exp_q.push_back(`CH_CR);
        exp_q.push_back(`CH_LF);
        rx_q.delete();
        bus(1'b1, `ADDR_CMD, {28'h0, c});
        // the hand-held waits for the full line before the next query
        while (n < 3000 && !(rx_q.size() >= exp_q.size() && rx_q[$] === `CH_LF))
        begin
            @(posedge clk_i);
            n++;
        end
        check("reply length", exp_q.size(), rx_q.size());
        foreach (exp_q[i]) if (i < rx_q.size()) check("reply byte", exp_q[i], rx_q[i]);
    endtask
    // a refused query stays silent and raises the sticky reject flag
    task automatic refuse(input logic [3:0] c);
        rx_q.delete();
        bus(1'b1, `ADDR_CMD, {28'h0, c});
        repeat (40) @(posedge clk_i);
        check("silent reply", 0, rx_q.size());
        bus(1'b0, `ADDR_STAT, 0);
        check("reject flag", 1, q[`STAT_REJECT]);
        bus(1'b1, `ADDR_STAT, 32'h2);
        bus(1'b0, `ADDR_STAT, 0);
        check("reject cleared", 0, q[`STAT_REJECT]);
    endtask
    // watchdog, far beyond the few thousand cycles needed
    initial
    begin
        #1000000;
        error_cnt++;
        $display("Error watchdog expired");
        complete_run();
    end
    // main sequence
    initial
    begin
        clk_i = 1'b0;
        reset_n_i = 1'b0;
        avs_address_i = 11'h000;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        slow = 1'b0;
        error_cnt = 0;
        num_checks = 0;
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        bus(1'b0, `ADDR_CTRL, 0);
        check("ctrl reset", 0, q);
        bus(1'b0, `ADDR_STAT, 0);
        check("stat reset", 0, q);
        bus(1'b1, 11'h010, 32'h5a);
        bus(1'b0, 11'h010, 0);
        check("unmapped", 0, q);
        for (int f = 0; f < 19; f++)
            for (int c = 0; c < 8; c++)
                bus(1'b1, `ADDR_FLD_BASE + 11'((f * 8 + c) * 4), {24'h0, fv[f][c]});
        for (int m = 0; m < 2; m++)
            for (int p = 0; p < 14; p++)
            begin
                bus(1'b1, `ADDR_CTRL, m);
                bus(1'b1, `ADDR_PHASE, p);
                run(`CMD_STATUS, $sformatf("7 S%02d", (m == 0 && p == 9) ? 8 :
                    (m == 0 && p == 11) ? 10 : p), 0);
            end
        bus(1'b0, `ADDR_CTRL, 0);
        check("ctrl readback", 1, q);
        bus(1'b1, `ADDR_PHASE, 0);
        slow <= 1'b1;
        bus(1'b1, `ADDR_CTRL, 0);
        run(`CMD_TOTALS, "7 12 50.5 900 849 T9", 1);
        bus(1'b1, `ADDR_CTRL, 32'h06);
        run(`CMD_TOTALS, "7 12 50.5 51.0 900 849 15 60 T9", 1);
        run(`CMD_AUX, "7 01/02/03 10:00 10:30 3 L", 1);
        slow <= 1'b0;
        run(`CMD_CLOCK, "7 04/05/06 11:22:33 0", 1);
        run(`CMD_RATE, "7 20.1 14.2", 0);
        run(`CMD_PRESET_Q, "7 60", 0);
        run(`CMD_SET_PRESET, "7 60", 0);
        bus(1'b1, `ADDR_CTRL, 32'h20);
        run(`CMD_CLOCK, "7 04/05/06 11:22:33 1", 1);
        run(`CMD_RATE, "7 20.1", 0);
        refuse(`CMD_PRESET_Q);
        bus(1'b1, `ADDR_CTRL, 32'h08);
        run(`CMD_DENSITY_Q, "7 0.51", 0);
        bus(1'b1, `ADDR_CTRL, 32'h10);
        run(`CMD_SET_DENS, "7 0.51", 0);
        bus(1'b1, `ADDR_CTRL, 32'h18);
        refuse(`CMD_DENSITY_Q);
        bus(1'b1, `ADDR_CTRL, 32'h80);
        run(`CMD_TOTALS, "7 S14", 0);
        bus(1'b0, `ADDR_STAT, 0);
        check("stat code", 32'h0000_0e00, q);
        run(`CMD_STATUS, "7 S00", 0);
        bus(1'b1, `ADDR_CTRL, 32'h40);
        run(`CMD_STATUS, "7 DS", 0);
        run(`CMD_TOTALS, "7 DS", 0);
        run(`CMD_CLOCK, "7 DS", 0);
        complete_run();
    end
endmodule // tb_delivery_status_reporter
bind delivery_status_reporter status_reporter_asserts #(.FLD_LEN(FLD_LEN)) u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
`default_nettype wire
